// ### dv/siit_interlock_tb.sv
`timescale 1ns/1ps
module siit_interlock_tb
    import siit_pkg::*;
;
    localparam int NREG = 16;

    logic sys_clk_i;
    logic rst_n_i;
    logic issue_i;
    siit_instr_t instr_i;
    logic issue_free_o;
    logic [NREG-1:0] reg_ready_o;
    logic acc_unit_free_o;
    logic acc_value_ready_o;
    logic accepted_o;
    logic refused_o;
    logic exp_q[$];
    int n_errors;
    int n_tests;
    int m;
    logic [31:0] rv;
    siit_instr_t ra;
    siit_instr_t rb;

    siit_interlock #(.NUM_REGS(NREG)) DUT (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .issue_i(issue_i),
        .instr_i(instr_i),
        .issue_free_o(issue_free_o),
        .reg_ready_o(reg_ready_o),
        .acc_unit_free_o(acc_unit_free_o),
        .acc_value_ready_o(acc_value_ready_o),
        .accepted_o(accepted_o),
        .refused_o(refused_o)
    );

    // 20 mhz clock
    always #25 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic siit_instr_t mk(siit_cls_t c, int d0, int d1, int s0, logic wr, logic u0, logic md, int mc);
        siit_instr_t r;
        r = '0;
        r.cls = c;
        r.dst0 = siit_idx_t'(d0);
        r.dst1 = siit_idx_t'(d1);
        r.src0 = siit_idx_t'(s0);
        r.wr_dst0 = wr;
        r.use_src0 = u0;
        r.mode_change = md;
        r.mac_cycles = 2'(mc);
        return r;
    endfunction

    // one offer per cycle; the verdict is noted for the monitor
    task automatic offer(input siit_instr_t ins, input logic acc);
        @(posedge sys_clk_i);
        issue_i <= 1'b1;
        instr_i <= ins;
        exp_q.push_back(acc);
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge sys_clk_i);
            issue_i <= 1'b0;
        end
    endtask

    // first instruction, then the second offered stall times to be refused and once more to be taken
    task automatic pair(input string name, input siit_instr_t a, input siit_instr_t b, input int stall);
        offer(a, 1'b1);
        repeat (stall) offer(b, 1'b0);
        offer(b, 1'b1);
        idle(8);
        $display("test %s done", name);
    endtask

    // one instruction, then the scoreboard flags just after it is taken
    task automatic probe(input string name, input siit_instr_t ins, input logic [31:0] exp);
        offer(ins, 1'b1);
        @(posedge sys_clk_i);
        issue_i <= 1'b0;
        #1;
        check({reg_ready_o, 13'h0, issue_free_o, acc_unit_free_o, acc_value_ready_o}, exp);
        idle(8);
        $display("test %s done", name);
    endtask

    // verdict monitor: a refusal is the stall the interlock imposed
    always @(posedge sys_clk_i)
    begin
        if (accepted_o === 1'b1 || refused_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                check({30'h0, accepted_o, refused_o}, 32'h0);
            else
                check({30'h0, accepted_o, refused_o}, {30'h0, exp_q[0], ~exp_q[0]});
            if (exp_q.size() != 0)
                exp_q.pop_front();
        end
    end

    // hang guard, bounded
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        summarize();
    end

    initial
    begin
        sys_clk_i = 1'b0;
        rst_n_i = 1'b0;
        issue_i = 1'b0;
        instr_i = '0;
        n_errors = 0;
        n_tests = 0;
        rv = $urandom(32'h581a);
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check({issue_free_o, acc_unit_free_o, acc_value_ready_o, accepted_o, refused_o}, 32'h1c);
        check(32'(reg_ready_o), 32'hffff);
        pair("normal indep", mk(CLS_NORMAL, 1, 0, 2, 1, 1, 0, 0), mk(CLS_NORMAL, 4, 0, 5, 1, 1, 0, 0), 0);
        pair("normal dep", mk(CLS_NORMAL, 1, 0, 2, 1, 1, 0, 0), mk(CLS_NORMAL, 4, 0, 1, 1, 1, 0, 0), 0);
        pair("swap word", mk(CLS_SWAP_WORD, 1, 0, 2, 1, 1, 0, 0), mk(CLS_NORMAL, 9, 0, 10, 1, 1, 0, 0), 4);
        pair("swap byte", mk(CLS_SWAP_BYTE, 1, 0, 2, 1, 1, 0, 0), mk(CLS_NORMAL, 9, 0, 10, 1, 1, 0, 0), 4);
        pair("accrd twice", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), mk(CLS_ACCUM_READ, 8, 9, 0, 0, 0, 0, 0), 1);
        pair("accrd indep", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), mk(CLS_NORMAL, 1, 0, 2, 1, 1, 0, 0), 0);
        pair("accrd dst1", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), mk(CLS_NORMAL, 1, 0, 7, 1, 1, 0, 0), 2);
        pair("accrd dst0", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), mk(CLS_NORMAL, 1, 0, 6, 1, 1, 0, 0), 1);
        // second source port and a late destination rewrite must wait as well
        rb = mk(CLS_NORMAL, 1, 0, 2, 1, 1, 0, 0);
        rb.src1 = 4'h7;
        rb.use_src1 = 1'b1;
        pair("accrd src1", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), rb, 2);
        pair("accrd waw", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), mk(CLS_NORMAL, 7, 0, 2, 1, 1, 0, 0), 2);
        pair("accwr next", mk(CLS_ACCUM_WRITE, 0, 0, 2, 0, 1, 0, 0), mk(CLS_NORMAL, 1, 0, 3, 1, 1, 0, 0), 1);
        pair("accwr accrd", mk(CLS_ACCUM_WRITE, 0, 0, 2, 0, 1, 0, 0), mk(CLS_ACCUM_READ, 4, 5, 0, 0, 0, 0, 0), 1);
        // every multiply duration, 0 counts as one cycle
        for (m = 0; m < 4; m++)
        begin
            pair("macw accrd", mk(CLS_MAC_WORD, 0, 0, 2, 0, 1, 0, m), mk(CLS_ACCUM_READ, 4, 5, 0, 0, 0, 0, 0),
                (m == 0) ? 0 : m - 1);
            pair("macw macw", mk(CLS_MAC_WORD, 0, 0, 2, 0, 1, 0, m), mk(CLS_MAC_WORD, 0, 0, 3, 0, 1, 0, 1),
                (m == 0) ? 0 : m - 1);
        end
        pair("mach mach", mk(CLS_MAC_HALF, 0, 0, 2, 0, 1, 0, 0), mk(CLS_MAC_HALF, 0, 0, 3, 0, 1, 0, 0), 1);
        pair("mach accrd", mk(CLS_MAC_HALF, 0, 0, 2, 0, 1, 0, 0), mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), 1);
        pair("status rd", mk(CLS_STATUS_READ, 3, 0, 0, 1, 0, 0, 0), mk(CLS_NORMAL, 1, 0, 3, 1, 1, 0, 0), 1);
        pair("status wr", mk(CLS_REG_TO_STATUS, 0, 0, 2, 0, 1, 0, 0), mk(CLS_NORMAL, 1, 0, 3, 1, 1, 0, 0), 1);
        pair("status mode", mk(CLS_REG_TO_STATUS, 0, 0, 2, 0, 1, 1, 0), mk(CLS_NORMAL, 1, 0, 3, 1, 1, 0, 0), 5);
        pair("coproc rd", mk(CLS_REG_FROM_COPROC, 7, 0, 0, 1, 0, 0, 0), mk(CLS_NORMAL, 1, 0, 7, 1, 1, 0, 0), 2);
        pair("coproc wr", mk(CLS_REG_TO_COPROC, 0, 0, 2, 0, 1, 0, 0), mk(CLS_NORMAL, 2, 0, 3, 1, 1, 0, 0), 0);
        pair("preload", mk(CLS_PRELOAD, 5, 0, 2, 1, 1, 0, 3), mk(CLS_NORMAL, 1, 0, 5, 1, 1, 0, 0), 0);
        pair("preload acc", mk(CLS_PRELOAD, 5, 0, 2, 1, 1, 0, 3), mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), 0);
        // flags one cycle after the take: registers, issue slot, unit, value
        probe("preload flags", mk(CLS_PRELOAD, 5, 0, 2, 1, 1, 0, 3), 32'hffff0007);
        probe("accwr flags", mk(CLS_ACCUM_WRITE, 0, 0, 2, 0, 1, 0, 0), 32'hffff0000);
        probe("accrd flags", mk(CLS_ACCUM_READ, 6, 7, 0, 0, 0, 0, 0), 32'hff3f0005);
        // random register fields on plain instructions never stall
        repeat (8)
        begin
            rv = $urandom();
            ra = rv[$bits(siit_instr_t)-1:0];
            ra.cls = CLS_NORMAL;
            rv = $urandom();
            rb = rv[$bits(siit_instr_t)-1:0];
            rb.cls = CLS_NORMAL;
            pair("random", ra, rb, 0);
        end
        // reset in mid stall clears the pending issue block
        offer(mk(CLS_SWAP_WORD, 1, 0, 2, 1, 1, 0, 0), 1'b1);
        @(posedge sys_clk_i);
        issue_i <= 1'b0;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check({31'h0, issue_free_o}, 32'h1);
        pair("after reset", mk(CLS_NORMAL, 1, 0, 2, 1, 1, 0, 0), mk(CLS_NORMAL, 4, 0, 5, 1, 1, 0, 0), 0);
        idle(3);
        check(32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule // siit_interlock_tb

// ### rtl/siit_interlock.sv
// Notes on behaviour
// RQ1: issue, result and resource latencies gate next, dependent and same-unit instructions.
// RQ2: word and byte swaps block the next issue for four cycles.
// RQ3: accumulator read issues in one cycle, keeps transfer unit two cycles.
// RQ4: a second accumulator read right after the first waits one cycle.
// RQ5: accumulator read: first destination ready after two, second after three.
// RQ6: accumulator write: two-cycle issue, result, resource; next always waits one.
// RQ7: word multiply-accumulate issues in one, result after one to three cycles.
// RQ8: word multiply-accumulate keeps the unit busy one to three cycles.
// RQ9: halfword multiply-accumulate: issue one, result two, unit busy two.
// RQ10: status read issues in one, destination usable two cycles later.
// RQ11: status write blocks the next issue one cycle, five on mode change; result one.
// RQ12: coprocessor-to-core transfer issues in one, destination ready after three.
// RQ13: core-to-coprocessor transfer lets the next instruction issue next cycle.
// RQ14: preload hint changes no tracked state at all.
`timescale 1ns/1ps
module siit_interlock
    import siit_pkg::*;
#(
    parameter int NUM_REGS = 16
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // instruction offered for issue
    input wire logic issue_i,
    input wire siit_instr_t instr_i,
    // scoreboard view for the issue stage
    output logic issue_free_o,
    output logic [NUM_REGS-1:0] reg_ready_o,
    output logic acc_unit_free_o,
    output logic acc_value_ready_o,
    // verdict on the last offer
    output logic accepted_o,
    output logic refused_o
);

    siit_top_st_t st_reg;
    siit_top_st_t st_next;
    logic ok;
    logic take;
    logic uses_unit;
    logic reads_acc;
    logic wr0;
    logic wr1;
    siit_lat_t issue_lat;
    siit_lat_t res_lat;
    siit_lat_t val_lat;
    siit_lat_t lat0;
    siit_lat_t lat1;
    siit_lat_t mac_lat;
    logic load_unit;
    logic load_val;
    logic [NUM_REGS-1:0] reg_load;
    siit_lat_t reg_lat [NUM_REGS];

    // operand-dependent multiply-accumulate time, zero taken as one
    assign mac_lat = (instr_i.mac_cycles == 2'h0) ? LAT_ONE : {1'b0, instr_i.mac_cycles};

    // per-class latencies and resource use
    always_comb
    begin
        issue_lat = LAT_ONE;
        res_lat = LAT_ONE;
        val_lat = LAT_ONE;
        lat0 = LAT_ONE;
        lat1 = LAT_ONE;
        uses_unit = 1'b0;
        reads_acc = 1'b0;
        wr0 = 1'b0;
        wr1 = 1'b0;
        case (instr_i.cls)
            CLS_SWAP_WORD, CLS_SWAP_BYTE:
            begin
                issue_lat = SWAP_ISSUE_LAT; // see RQ2
                wr0 = instr_i.wr_dst0;
            end
            CLS_ACCUM_READ:
            begin
                issue_lat = ACCRD_ISSUE_LAT; // see RQ3
                res_lat = ACCRD_RES_LAT; // see RQ4
                lat0 = ACCRD_DST0_LAT; // see RQ5
                lat1 = ACCRD_DST1_LAT; // see RQ5
                uses_unit = 1'b1;
                reads_acc = 1'b1;
                wr0 = 1'b1;
                wr1 = 1'b1;
            end
            CLS_ACCUM_WRITE:
            begin
                issue_lat = ACCWR_LAT; // see RQ6
                res_lat = ACCWR_LAT;
                val_lat = ACCWR_LAT;
                uses_unit = 1'b1;
            end
            CLS_MAC_WORD:
            begin
                issue_lat = MACW_ISSUE_LAT; // see RQ7
                res_lat = mac_lat; // see RQ8
                val_lat = mac_lat; // see RQ7
                uses_unit = 1'b1;
            end
            CLS_MAC_HALF:
            begin
                issue_lat = MACH_ISSUE_LAT; // see RQ9
                res_lat = MACH_RES_LAT;
                val_lat = MACH_RESULT_LAT;
                uses_unit = 1'b1;
            end
            CLS_STATUS_READ:
            begin
                issue_lat = STRD_ISSUE_LAT; // see RQ10
                lat0 = STRD_RESULT_LAT;
                wr0 = 1'b1;
            end
            CLS_REG_TO_STATUS:
            begin
                // status result latency of one needs no tracking here
                issue_lat = instr_i.mode_change ? STWR_MODE_ISSUE_LAT : STWR_ISSUE_LAT; // see RQ11
                lat0 = STWR_RESULT_LAT;
            end
            CLS_REG_FROM_COPROC:
            begin
                issue_lat = CPRD_ISSUE_LAT; // see RQ12
                lat0 = CPRD_RESULT_LAT;
                wr0 = 1'b1;
            end
            CLS_REG_TO_COPROC:
            begin
                issue_lat = CPWR_ISSUE_LAT; // see RQ13
            end
            CLS_PRELOAD:
            begin
                issue_lat = LAT_ONE; // see RQ14
            end
            default:
            begin
                wr0 = instr_i.wr_dst0;
            end
        endcase
    end

    // acceptance: issue slot, operands, destinations and accumulator unit
    // destinations must be settled too, so a late result never lands after a newer one
    always_comb
    begin
        ok = issue_free_o; // see RQ1
        if (instr_i.use_src0 && !reg_ready_o[instr_i.src0])
        begin
            ok = 1'b0;
        end
        if (instr_i.use_src1 && !reg_ready_o[instr_i.src1])
        begin
            ok = 1'b0;
        end
        if ((wr0 && !reg_ready_o[instr_i.dst0]) || (wr1 && !reg_ready_o[instr_i.dst1]))
        begin
            ok = 1'b0;
        end
        if ((uses_unit && !acc_unit_free_o) || (reads_acc && !acc_value_ready_o))
        begin
            ok = 1'b0; // see RQ1
        end
    end

    assign take = issue_i && ok;
    assign load_unit = take && uses_unit;
    assign load_val = take && (instr_i.cls != CLS_ACCUM_READ) && uses_unit;

    // per-register load requests; second destination wins on a clash
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            reg_load[i] = take && ((wr0 && instr_i.dst0 == i[REG_IDX_W-1:0]) ||
                (wr1 && instr_i.dst1 == i[REG_IDX_W-1:0]));
            reg_lat[i] = (wr1 && instr_i.dst1 == i[REG_IDX_W-1:0]) ? lat1 : lat0; // see RQ5
        end
    end

    // one timer per core register
    generate
        for (genvar g = 0; g < NUM_REGS; g++)
        begin : g_reg
            siit_lat_timer u_reg_timer (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .load_i(reg_load[g]),
                .lat_i(reg_lat[g]),
                .free_o(reg_ready_o[g])
            );
        end
    endgenerate

    // issue slot timer
    siit_lat_timer u_issue_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(take),
        .lat_i(issue_lat),
        .free_o(issue_free_o)
    );

    // accumulator unit occupancy
    siit_lat_timer u_unit_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load_unit),
        .lat_i(res_lat),
        .free_o(acc_unit_free_o)
    );

    // accumulator value readiness
    siit_lat_timer u_val_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load_val),
        .lat_i(val_lat),
        .free_o(acc_value_ready_o)
    );

    // verdict flags, one cycle after the offer
    always_comb
    begin
        st_next.accepted = take;
        st_next.refused = issue_i && !ok;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign accepted_o = st_reg.accepted;
    assign refused_o = st_reg.refused;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_swap_issue_block: assert property ( // see RQ2
        take && (instr_i.cls == CLS_SWAP_WORD || instr_i.cls == CLS_SWAP_BYTE)
        |=> !issue_free_o [*4] ##1 issue_free_o)
        else $error("swap did not block issue for four cycles");
    a_accrd_issue_one: assert property ( // see RQ3
        take && instr_i.cls == CLS_ACCUM_READ |=> issue_free_o && !acc_unit_free_o ##1 acc_unit_free_o)
        else $error("accumulator read issue or unit latency wrong");
    a_accrd_back_stall: assert property ( // see RQ4
        take && instr_i.cls == CLS_ACCUM_READ ##1 issue_i && instr_i.cls == CLS_ACCUM_READ |-> !take)
        else $error("back-to-back accumulator read not stalled");
    a_accrd_dst_late: assert property ( // see RQ5
        take && instr_i.cls == CLS_ACCUM_READ && instr_i.dst0 != instr_i.dst1
        |=> !reg_ready_o[$past(instr_i.dst0)] && !reg_ready_o[$past(instr_i.dst1)]
        ##1 reg_ready_o[$past(instr_i.dst0, 2)] && !reg_ready_o[$past(instr_i.dst1, 2)]
        ##1 reg_ready_o[$past(instr_i.dst1, 3)])
        else $error("accumulator read destination timing wrong");
    a_accwr_stall_one: assert property ( // see RQ6
        take && instr_i.cls == CLS_ACCUM_WRITE |=> !issue_free_o && !acc_value_ready_o ##1 issue_free_o)
        else $error("accumulator write did not stall one cycle");
    a_macw_unit_busy: assert property ( // see RQ8
        take && instr_i.cls == CLS_MAC_WORD && instr_i.mac_cycles == 2'h3
        |=> issue_free_o && !acc_unit_free_o ##1 !acc_unit_free_o ##1 acc_unit_free_o)
        else $error("word multiply-accumulate busy time wrong");
    a_macw_fast_free: assert property ( // see RQ7
        take && instr_i.cls == CLS_MAC_WORD && instr_i.mac_cycles == 2'h1 |=> acc_value_ready_o)
        else $error("fast multiply-accumulate result not ready");
    a_mach_result_two: assert property ( // see RQ9
        take && instr_i.cls == CLS_MAC_HALF |=> !acc_value_ready_o && !acc_unit_free_o ##1 acc_value_ready_o)
        else $error("halfword multiply-accumulate timing wrong");
    a_strd_result_two: assert property ( // see RQ10
        take && instr_i.cls == CLS_STATUS_READ |=> !reg_ready_o[$past(instr_i.dst0)]
        ##1 reg_ready_o[$past(instr_i.dst0, 2)])
        else $error("status read result latency wrong");
    a_stwr_mode_block: assert property ( // see RQ11
        take && instr_i.cls == CLS_REG_TO_STATUS && instr_i.mode_change |=> !issue_free_o [*5] ##1 issue_free_o)
        else $error("mode-changing status write issue latency wrong");
    a_cprd_result_three: assert property ( // see RQ12
        take && instr_i.cls == CLS_REG_FROM_COPROC |=> issue_free_o && !reg_ready_o[$past(instr_i.dst0)]
        ##2 reg_ready_o[$past(instr_i.dst0, 3)])
        else $error("coprocessor read result latency wrong");
    a_cpwr_issue_next: assert property ( // see RQ13
        take && instr_i.cls == CLS_REG_TO_COPROC |=> issue_free_o)
        else $error("coprocessor write blocked the next issue");
    a_preload_no_effect: assert property ( // see RQ14
        take && instr_i.cls == CLS_PRELOAD |-> reg_load == '0 && !load_unit && !load_val)
        else $error("preload changed tracked state");

    c_swap_seen: cover property (take && instr_i.cls == CLS_SWAP_BYTE);
    c_accrd_refused: cover property (issue_i && instr_i.cls == CLS_ACCUM_READ && !acc_unit_free_o);
    c_mac_then_read: cover property (take && instr_i.cls == CLS_MAC_WORD ##[1:3] take && instr_i.cls == CLS_ACCUM_READ);
    c_mode_write: cover property (take && instr_i.cls == CLS_REG_TO_STATUS && instr_i.mode_change);

endmodule // siit_interlock

// ### rtl/siit_lat_timer.sv
`timescale 1ns/1ps
module siit_lat_timer
    import siit_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // load a latency in cycles, 1 or more
    input wire logic load_i,
    input wire siit_lat_t lat_i,
    // high while the tracked item may be used this cycle
    output logic free_o
);

    siit_timer_st_t st_reg;
    siit_timer_st_t st_next;

    // countdown: a latency of n frees the item n cycles after the load
    always_comb
    begin
        st_next = st_reg;
        if (load_i)
        begin
            st_next.cnt = (lat_i == TIMER_RST_CNT) ? TIMER_RST_CNT : lat_i - LAT_ONE;
        end
        else if (st_reg.cnt != TIMER_RST_CNT)
        begin
            st_next.cnt = st_reg.cnt - LAT_ONE;
        end
        st_next.free = (st_next.cnt == TIMER_RST_CNT);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_reg.cnt <= TIMER_RST_CNT;
            st_reg.free <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign free_o = st_reg.free;

endmodule // siit_lat_timer

// ### rtl/siit_pkg.sv
package siit_pkg;

    // register index width and latency counter width
    localparam int REG_IDX_W = 4;
    localparam int LAT_W = 3;

    typedef logic [LAT_W-1:0] siit_lat_t;
    typedef logic [REG_IDX_W-1:0] siit_idx_t;

    // latencies in issue cycles, as counted from the issuing cycle
    localparam siit_lat_t LAT_ONE = 3'h1;
    localparam siit_lat_t SWAP_ISSUE_LAT = 3'h5;
    localparam siit_lat_t ACCRD_ISSUE_LAT = 3'h1;
    localparam siit_lat_t ACCRD_RES_LAT = 3'h2;
    localparam siit_lat_t ACCRD_DST0_LAT = 3'h2;
    localparam siit_lat_t ACCRD_DST1_LAT = 3'h3;
    localparam siit_lat_t ACCWR_LAT = 3'h2;
    localparam siit_lat_t MACW_ISSUE_LAT = 3'h1;
    localparam siit_lat_t MACH_ISSUE_LAT = 3'h1;
    localparam siit_lat_t MACH_RESULT_LAT = 3'h2;
    localparam siit_lat_t MACH_RES_LAT = 3'h2;
    localparam siit_lat_t STRD_ISSUE_LAT = 3'h1;
    localparam siit_lat_t STRD_RESULT_LAT = 3'h2;
    localparam siit_lat_t STWR_ISSUE_LAT = 3'h2;
    localparam siit_lat_t STWR_MODE_ISSUE_LAT = 3'h6;
    localparam siit_lat_t STWR_RESULT_LAT = 3'h1;
    localparam siit_lat_t CPRD_ISSUE_LAT = 3'h1;
    localparam siit_lat_t CPRD_RESULT_LAT = 3'h3;
    localparam siit_lat_t CPWR_ISSUE_LAT = 3'h1;

    // reset values of a latency timer
    localparam siit_lat_t TIMER_RST_CNT = 3'h0;

    // instruction classes seen by the interlock
    typedef enum logic [3:0] {
        CLS_NORMAL,
        CLS_SWAP_WORD,
        CLS_SWAP_BYTE,
        CLS_ACCUM_READ,
        CLS_ACCUM_WRITE,
        CLS_MAC_WORD,
        CLS_MAC_HALF,
        CLS_STATUS_READ,
        CLS_REG_TO_STATUS,
        CLS_REG_FROM_COPROC,
        CLS_REG_TO_COPROC,
        CLS_PRELOAD
    } siit_cls_t;

    // one instruction offered for issue
    typedef struct packed {
        siit_cls_t cls;
        siit_idx_t dst0;
        siit_idx_t dst1;
        siit_idx_t src0;
        siit_idx_t src1;
        logic wr_dst0;
        logic use_src0;
        logic use_src1;
        logic mode_change;
        logic [1:0] mac_cycles;
    } siit_instr_t;

    // state of one latency timer
    typedef struct packed {
        siit_lat_t cnt;
        logic free;
    } siit_timer_st_t;

    // state of the interlock top
    typedef struct packed {
        logic accepted;
        logic refused;
    } siit_top_st_t;

endpackage
